// File: logic/port_power_pkg.sv
// constants shared by the downstream port power and overcurrent block
// assumes one 250 MHz clock and an active-low asynchronous chip reset
// How it works
// - there is one power and overcurrent pin for each port 1 to 7 and one for port 0.
// - outside ganged mode an enabled port's pin is released as an input with its pull-up on, which powers the port.
// - outside ganged mode a low level on an enabled port's pin means the current monitor reports an overcurrent.
// - outside ganged mode a port disabled by configuration or by the host has its pin driven low to cut power.
// - the port 0 pin controls power only while the roles are swapped and port 0 is downstream.
// - the upstream power detect input is sampled to tell whether upstream power is present.
// - a rise of upstream power detect makes the hub reconnect upstream without a chip reset.
// - during reset every pin output driver is switched off.
// - during reset the weak pull-downs on the port pins hold port power off.
// - during reset the pull-downs on the data pins that carry the port-off straps are on.
// - signals whose names end in the low-active suffix, reset among them, act at low level.
// - the role swap request low keeps port 0 upstream, high makes port 0 downstream.
// - in ganged mode the shared pin controls the power of all downstream ports together.
// - straps are caught after power-on reset and after each release of the chip reset.
// - a low chip reset puts the whole block in reset.
package port_power_pkg;
  localparam int PORT_COUNT     = 8;
  localparam int SWAP_PORT      = 0;
  localparam int FLEX_PORT      = 1;
  localparam int SHARED_PORT    = 4;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int OC_SETTLE_NS   = 100;
  localparam int OC_SETTLE_CYCLES =
    (OC_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int STRAP_SETTLE_CYCLES = 4;
  localparam logic RESET_PULLDOWN = 1'b1;
  localparam logic RESET_DRIVE    = 1'b0;
  typedef enum logic [1:0] {ST_STRAP_WAIT, ST_RUN} phase_type;
endpackage

// File: logic/pin_sync.sv
// three-stage synchroniser for pin inputs with agreement filter
// assumes inputs are asynchronous to CLOCK
module pin_sync #(
  parameter int         WIDTH = 1,
  parameter logic [7:0] INIT  = 8'h00
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] raw,
  output      logic [WIDTH-1:0] stable
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // reset value fitted to the bus width, which may exceed eight bits
  localparam logic [WIDTH-1:0] RESET_VALUE = WIDTH'(INIT);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only once the second and third stage agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stable <= RESET_VALUE;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          stable[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// File: logic/port_power_ctl.sv
// downstream port power enable and overcurrent sense control
// assumes pin pull resistors are realised outside from the enable outputs
module port_power_ctl #(
  parameter int PORTS = port_power_pkg::PORT_COUNT
) (
  input  wire logic             CLOCK,
  input  wire logic             RESET_N,
  input  wire logic [PORTS-1:0] PORT_POWER_SENSE_PIN_IN,
  output      logic [PORTS-1:0] PORT_POWER_SENSE_PIN_OUT,
  output      logic [PORTS-1:0] PORT_POWER_SENSE_PIN_OE,
  output      logic [PORTS-1:0] PORT_PULLUP_EN,
  output      logic [PORTS-1:0] WEAK_PULLDOWN_RESET_STATE,
  output      logic             DATA_PULLDOWN_RESET_STATE,
  input  wire logic [PORTS-1:1] PORT_OFF_STRAP_PLUS,
  input  wire logic [PORTS-1:1] PORT_OFF_STRAP_MINUS,
  input  wire logic [PORTS-1:0] CONFIG_PORT_ENABLE,
  input  wire logic [PORTS-1:0] HOST_PORT_ENABLE,
  input  wire logic             GANGED_MODE,
  input  wire logic             ROLE_SWAP_REQUEST,
  output      logic             ROLE_SWAPPED,
  input  wire logic             UPSTREAM_POWER_DETECT,
  output      logic             UPSTREAM_POWER_PRESENT,
  output      logic             RECONNECT_PULSE,
  output      logic [PORTS-1:0] OVERCURRENT,
  output      logic [PORTS-1:0] STRAP_PORT_OFF
);
  localparam int CW = $clog2(port_power_pkg::OC_SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_MAX =
    CW'(port_power_pkg::OC_SETTLE_CYCLES);
  localparam logic [2:0] STRAP_MAX =
    3'(port_power_pkg::STRAP_SETTLE_CYCLES);

  port_power_pkg::phase_type phase;
  logic [2:0]       strap_count;
  logic [PORTS-1:0] sense;
  logic [PORTS-1:1] strap_plus;
  logic [PORTS-1:1] strap_minus;
  logic             role_sync;
  logic             vbus_sync;
  logic [PORTS-1:0] port_en;
  logic [PORTS-1:0] port_en_q;
  logic [PORTS-1:0] next_pin_en;
  logic [PORTS-1:0] settled;
  logic [PORTS-1:0] oc_set;
  logic             shared_oc;

  // pin inputs are synchronised before use
  pin_sync #(.WIDTH(PORTS), .INIT(8'hff)) sense_sync (
    .clock   (CLOCK),
    .reset_n (RESET_N),
    .raw     (PORT_POWER_SENSE_PIN_IN),
    .stable  (sense)
  );
  pin_sync #(.WIDTH(2 * (PORTS - 1)), .INIT(8'h00)) strap_sync (
    .clock   (CLOCK),
    .reset_n (RESET_N),
    .raw     ({PORT_OFF_STRAP_PLUS, PORT_OFF_STRAP_MINUS}),
    .stable  ({strap_plus, strap_minus})
  );
  pin_sync #(.WIDTH(2), .INIT(8'h00)) misc_sync (
    .clock   (CLOCK),
    .reset_n (RESET_N),
    .raw     ({ROLE_SWAP_REQUEST, UPSTREAM_POWER_DETECT}),
    .stable  ({role_sync, vbus_sync})
  );

  // whether port i may act downstream under the current roles
  function automatic logic role_allows(input int i, input logic swapped);
    if (i == port_power_pkg::SWAP_PORT) begin
      role_allows = swapped;
    end else if (i == port_power_pkg::FLEX_PORT) begin
      role_allows = !swapped;
    end else begin
      role_allows = 1'b1;
    end
  endfunction

  // straps are caught once the synchronisers have filled after release
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase       <= port_power_pkg::ST_STRAP_WAIT;
      strap_count <= 3'h0;
    end else begin
      case (phase)
        port_power_pkg::ST_STRAP_WAIT: begin
          if (strap_count == STRAP_MAX) begin
            phase <= port_power_pkg::ST_RUN;
          end else begin
            strap_count <= strap_count + 3'h1;
          end
        end
        port_power_pkg::ST_RUN: begin
          phase <= port_power_pkg::ST_RUN;
        end
        default: begin
          phase <= port_power_pkg::ST_STRAP_WAIT;
        end
      endcase
    end
  end

  // both halves of a data pair pulled high mark the port as off
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      STRAP_PORT_OFF <= '0;
    end else if (phase == port_power_pkg::ST_STRAP_WAIT
                 && strap_count == STRAP_MAX) begin
      STRAP_PORT_OFF <= {strap_plus & strap_minus, 1'b0};
    end
  end

  // data pin pull-downs stay on until straps are caught
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_PULLDOWN_RESET_STATE <= port_power_pkg::RESET_PULLDOWN;
      WEAK_PULLDOWN_RESET_STATE <= {PORTS{port_power_pkg::RESET_PULLDOWN}};
    end else begin
      DATA_PULLDOWN_RESET_STATE <=
        (phase != port_power_pkg::ST_RUN);
      WEAK_PULLDOWN_RESET_STATE <=
        {PORTS{phase != port_power_pkg::ST_RUN}};
    end
  end

  // port enable and pin enable from config, host, straps and roles
  always_comb begin
    next_pin_en = '0;
    port_en     = '0;
    for (int i = 0; i < PORTS; i++) begin
      port_en[i] = (phase == port_power_pkg::ST_RUN)
                   && role_allows(i, role_sync)
                   && CONFIG_PORT_ENABLE[i] && HOST_PORT_ENABLE[i]
                   && !STRAP_PORT_OFF[i];
    end
    if (GANGED_MODE) begin
      next_pin_en[port_power_pkg::SHARED_PORT] = |port_en;
    end else begin
      next_pin_en = port_en;
    end
  end

  // enabled pins float with pull-up; once running, disabled pins are driven low except non-shared pins in ganged mode, which float
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      PORT_POWER_SENSE_PIN_OE  <= '0;
      PORT_POWER_SENSE_PIN_OUT <= {PORTS{port_power_pkg::RESET_DRIVE}};
      PORT_PULLUP_EN           <= '0;
      port_en_q                <= '0;
    end else begin
      PORT_PULLUP_EN <= next_pin_en;
      port_en_q      <= port_en;
      for (int i = 0; i < PORTS; i++) begin
        PORT_POWER_SENSE_PIN_OE[i] <=
          (phase == port_power_pkg::ST_RUN) && !next_pin_en[i]
          && !(GANGED_MODE && i != port_power_pkg::SHARED_PORT);
      end
    end
  end

  // settle time after release so the rising pin is not read as a fault
  generate
    for (genvar g = 0; g < PORTS; g++) begin : g_settle
      logic [CW-1:0] count;
      always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
          count <= '0;
        end else if (!PORT_PULLUP_EN[g]) begin
          count <= '0;
        end else if (count != SETTLE_MAX) begin
          count <= count + CW'(1);
        end
      end
      assign settled[g] = (count == SETTLE_MAX);
    end
  endgenerate

  // a low sense level on a released, settled pin is an overcurrent
  always_comb begin
    shared_oc = settled[port_power_pkg::SHARED_PORT]
                && PORT_PULLUP_EN[port_power_pkg::SHARED_PORT]
                && !sense[port_power_pkg::SHARED_PORT];
    if (GANGED_MODE) begin
      oc_set = {PORTS{shared_oc}} & port_en;
    end else begin
      oc_set = settled & PORT_PULLUP_EN & ~sense & port_en;
    end
  end

  // flags hold until the port is disabled
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      OVERCURRENT <= '0;
    end else begin
      OVERCURRENT <= (OVERCURRENT | oc_set) & port_en;
    end
  end

  // role and upstream power tracking, reconnect on each power return
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ROLE_SWAPPED           <= 1'b0;
      UPSTREAM_POWER_PRESENT <= 1'b0;
      RECONNECT_PULSE        <= 1'b0;
    end else begin
      ROLE_SWAPPED           <= role_sync;
      UPSTREAM_POWER_PRESENT <= vbus_sync;
      RECONNECT_PULSE        <=
        vbus_sync && !UPSTREAM_POWER_PRESENT;
    end
  end

  chk_reset_no_drive: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $past(phase) != port_power_pkg::ST_RUN |-> PORT_POWER_SENSE_PIN_OE == '0)
    else $error("pin driven before straps caught");

  chk_pulldown_hold: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $fell(WEAK_PULLDOWN_RESET_STATE[0])
      |-> $past(phase, 1) == port_power_pkg::ST_RUN
      && DATA_PULLDOWN_RESET_STATE == 1'b0)
    else $error("pull-downs released out of step");

  chk_strap_bound: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $rose(RESET_N) or phase == port_power_pkg::ST_STRAP_WAIT
      |-> ##[1:6] phase == port_power_pkg::ST_RUN)
    else $error("strap phase too long");

  chk_pull_or_drive: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    (PORT_PULLUP_EN & PORT_POWER_SENSE_PIN_OE) == '0
      && (PORT_PULLUP_EN & WEAK_PULLDOWN_RESET_STATE) == '0)
    else $error("pull-up fights a driver");

  chk_swap_roles: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    !ROLE_SWAPPED |-> !PORT_PULLUP_EN[port_power_pkg::SWAP_PORT]
      && !OVERCURRENT[port_power_pkg::SWAP_PORT])
    else $error("port 0 powered while upstream");

  chk_flex_upstream: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    ROLE_SWAPPED |-> !PORT_PULLUP_EN[port_power_pkg::FLEX_PORT])
    else $error("port 1 powered while upstream");

  chk_oc_capture: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    oc_set != '0 |=> (($past(oc_set) & ~OVERCURRENT) == '0))
    else $error("overcurrent not flagged");

  chk_oc_sticky: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    (OVERCURRENT & ~port_en_q) == '0
      && ((($past(OVERCURRENT) & port_en_q) & ~OVERCURRENT) == '0))
    else $error("overcurrent flag lost while enabled");

  chk_reconnect_pulse: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RECONNECT_PULSE == $rose(UPSTREAM_POWER_PRESENT)
      and (RECONNECT_PULSE |=> !RECONNECT_PULSE))
    else $error("reconnect pulse mismatch");
endmodule

// File: dv/power_switch_model.sv
// external port power switches with their current monitors, one per pin
// assumes the pin pulls are realised here from the design's enable outputs
module power_switch_model (
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_down,
  input  wire logic [7:0] fault,
  output      logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 8'h00;
  // resolves each shared pin; a floating pin shows no stale level
  always @(oe, pull_up, pull_down, fault) begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i] || fault[i]) pin[i] = 1'b0;
      else if (pull_up[i]) pin[i] = 1'b1;
      else if (pull_down[i]) pin[i] = 1'b0;
      else pin[i] = ~pin[i];
    end
  end
endmodule

// File: dv/tb_top.sv
// self-checking bench for the port power and overcurrent block
// assumes the switch model resolves the pins; 250 MHz clock
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       CLOCK, RESET_N, GANGED_MODE, ROLE_SWAP_REQUEST;
  logic       UPSTREAM_POWER_DETECT;
  logic [7:0] pin, pout, oe, pu, wpd, cfg, host, fault, oc, soff;
  logic [7:1] splus, sminus;
  logic       dpd, swapped, present, recon;
  int         error_cnt, checks_done;
  port_power_ctl dut_u (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .PORT_POWER_SENSE_PIN_IN(pin), .PORT_POWER_SENSE_PIN_OUT(pout),
    .PORT_POWER_SENSE_PIN_OE(oe), .PORT_PULLUP_EN(pu),
    .WEAK_PULLDOWN_RESET_STATE(wpd), .DATA_PULLDOWN_RESET_STATE(dpd),
    .PORT_OFF_STRAP_PLUS(splus), .PORT_OFF_STRAP_MINUS(sminus),
    .CONFIG_PORT_ENABLE(cfg), .HOST_PORT_ENABLE(host),
    .GANGED_MODE(GANGED_MODE), .ROLE_SWAP_REQUEST(ROLE_SWAP_REQUEST),
    .ROLE_SWAPPED(swapped), .UPSTREAM_POWER_DETECT(UPSTREAM_POWER_DETECT),
    .UPSTREAM_POWER_PRESENT(present), .RECONNECT_PULSE(recon),
    .OVERCURRENT(oc), .STRAP_PORT_OFF(soff));
  power_switch_model model_u (.oe(oe), .pull_up(pu), .pull_down(wpd),
    .fault(fault), .pin(pin));
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  // reset with the current straps, checks pin states inside reset
  task automatic do_reset();
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    cyc(5);
    chk("oe in reset", 8'h00, oe);
    chk("weak pd", 8'hff, wpd);
    chk("data pd", 8'h01, {7'h00, dpd});
    chk("oc in reset", 8'h00, oc);
    @(posedge CLOCK);
    RESET_N <= 1'b1;
    cyc(10);
  endtask
  task automatic t_enable();
    chk("pullup", 8'hfe, pu);
    chk("oe port0", 8'h01, oe);
    chk("drive value", 8'h00, pout);
    chk("weak pd run", 8'h00, wpd);
    chk("data pd run", 8'h00, {7'h00, dpd});
    @(posedge CLOCK);
    host <= 8'hfb;
    cyc(2);
    chk("oe host off", 8'h05, oe);
    @(posedge CLOCK);
    cfg <= 8'hf7;
    host <= 8'hff;
    cyc(2);
    chk("oe cfg off", 8'h09, oe);
    chk("pullup cfg off", 8'hf6, pu);
    @(posedge CLOCK);
    cfg <= 8'hff;
    cyc(1);
  endtask
  task automatic t_overcurrent();
    bit seen;
    cyc(30);
    @(posedge CLOCK);
    fault[3] <= 1'b1;
    for (int i = 0; i < 12 && !seen; i++) begin
      cyc(1);
      seen = oc[3];
    end
    chk("oc set", 8'h08, oc);
    @(posedge CLOCK);
    fault[3] <= 1'b0;
    cyc(8);
    chk("oc sticky", 8'h08, oc);
    @(posedge CLOCK);
    host[3] <= 1'b0;
    cyc(2);
    chk("oc cleared", 8'h00, oc);
    @(posedge CLOCK);
    host[3] <= 1'b1;
    cyc(1);
  endtask
  task automatic t_swap();
    @(posedge CLOCK);
    ROLE_SWAP_REQUEST <= 1'b1;
    cyc(9);
    chk("swapped", 8'h01, {7'h00, swapped});
    chk("pullup swap", 8'hfd, pu);
    chk("oe swap", 8'h02, oe);
  endtask
  task automatic t_upstream();
    int pulses;
    @(posedge CLOCK);
    UPSTREAM_POWER_DETECT <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      cyc(1);
      if (recon === 1'b1) pulses++;
    end
    chk("reconnect pulses", 8'h01, 8'(pulses));
    chk("present", 8'h01, {7'h00, present});
  endtask
  task automatic t_gang();
    @(posedge CLOCK);
    GANGED_MODE <= 1'b1;
    cyc(3);
    chk("gang pullup", 8'h10, pu);
    chk("gang oe", 8'h00, oe);
    @(posedge CLOCK);
    fault[4] <= 1'b1;
    cyc(8);
    chk("gang oc", 8'hfd, oc);
    @(posedge CLOCK);
    fault[4] <= 1'b0;
    GANGED_MODE <= 1'b0;
    cyc(2);
  endtask
  task automatic t_strap();
    @(posedge CLOCK);
    splus <= 7'h10;
    sminus <= 7'h10;
    do_reset();
    chk("strap off", 8'h20, soff);
    chk("strap oe", 8'h21, oe);
  endtask
  initial begin
    RESET_N = 1'b0;
    GANGED_MODE = 1'b0;
    ROLE_SWAP_REQUEST = 1'b0;
    UPSTREAM_POWER_DETECT = 1'b0;
    cfg = 8'hff;
    host = 8'hff;
    fault = 8'h00;
    splus = 7'h00;
    sminus = 7'h7f;
    error_cnt = 0;
    checks_done = 0;
    do_reset();
    t_enable();
    t_overcurrent();
    t_upstream();
    t_swap();
    t_gang();
    @(posedge CLOCK);
    ROLE_SWAP_REQUEST <= 1'b0;
    t_strap();
    stop_test();
  end
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule
